// File: bench/address_generator_tb.sv
// self-checking bench for the x and y address generators and their register map
// assumes the partner model drives the request ports and the bench drives the register bus
`timescale 1ns/1ns
module address_generator_tb;
    import agen_pkg::*;
    logic clk_sys_i = 1'b0;
    logic srst_i = 1'b1;
    logic [15:0] reg_addr_i = 16'h0000;
    logic [15:0] reg_wdata_i = 16'h0000;
    logic reg_wr_i = 1'b0;
    logic reg_rd_i = 1'b0;
    x_req_t x_req_i;
    y_req_t y_req_i;
    wb_req_t wb_req_i;
    x_out_t x_out_o;
    y_out_t y_out_o;
    logic [15:0] reg_rdata_o;
    int n_mismatch = 0;
    int n_tests = 0;
    // offsets, reset values and read back after writing all ones (last is unmapped)
    localparam logic [15:0] OFS [9] = '{16'h0046, 16'h0048, 16'h004a, 16'h004c, 16'h004e,
        16'h0050, 16'h0052, 16'h0220, 16'h0060};
    localparam logic [15:0] RST [9] = '{16'h0000, 16'h0000, 16'h0001, 16'h0000, 16'h0001,
        16'h0000, 16'h0000, 16'h0000, 16'h0000};
    localparam logic [15:0] ONES [9] = '{16'hcfff, 16'hfffe, 16'hffff, 16'hfffe, 16'hffff,
        16'hffff, 16'h3fff, 16'h0007, 16'h0000};

    // 250 MHz core clock
    always #2 clk_sys_i = ~clk_sys_i;

    agen_partner agen_partner_inst (
        .clk_sys_i(clk_sys_i),
        .x_req_o(x_req_i),
        .y_req_o(y_req_i),
        .wb_req_o(wb_req_i)
    );

    address_generator address_generator_inst (
        .clk_sys_i(clk_sys_i),
        .srst_i(srst_i),
        .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i),
        .reg_wr_i(reg_wr_i),
        .reg_rd_i(reg_rd_i),
        .x_req_i(x_req_i),
        .y_req_i(y_req_i),
        .wb_req_i(wb_req_i),
        .x_out_o(x_out_o),
        .y_out_o(y_out_o),
        .reg_rdata_o(reg_rdata_o)
    );

    // compare a 16-bit result against its expectation
    task automatic cmp16(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic reg_wr(input logic [15:0] a, input logic [15:0] d);
        @(posedge clk_sys_i);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= 1'b1;
        @(posedge clk_sys_i);
        reg_wr_i <= 1'b0;
    endtask

    // read data stands only in the cycle after the strobe
    task automatic reg_chk(input logic [15:0] a, input logic [15:0] exp);
        @(posedge clk_sys_i);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        @(posedge clk_sys_i);
        reg_rd_i <= 1'b0;
        #1;
        cmp16(reg_rdata_o, exp);
    endtask

    function automatic x_req_t xr(input addr_mode_t m, input logic [3:0] p, input logic [3:0] o,
        input logic [15:0] l, input logic b, input logic d);
        xr = '0;
        xr.valid = 1'b1;
        xr.mode = m;
        xr.ptr = p;
        xr.offs = o;
        xr.lit = l;
        xr.byte_acc = b;
        xr.dec = d;
    endfunction

    function automatic wb_req_t wbr(input logic [3:0] i, input logic [15:0] d, input logic imp);
        wbr = '0;
        wbr.valid = 1'b1;
        wbr.idx = i;
        wbr.data = d;
        wbr.implied = imp;
    endfunction

    // issue one x request and check its effective address
    task automatic x_chk(input x_req_t r, input logic [15:0] exp);
        agen_partner_inst.issue(r, '0, '0);
        #1;
        cmp16(x_out_o.ea, exp);
    endtask

    // reset values, write masks, unmapped place, read data withdrawn
    task automatic test_regs;
        for (int i = 0; i < 9; i++)
        begin
            reg_chk(OFS[i], RST[i]);
            reg_wr(OFS[i], 16'hffff);
            reg_chk(OFS[i], ONES[i]);
            reg_wr(OFS[i], 16'h0000);
        end
        @(posedge clk_sys_i);
        #1;
        cmp16(reg_rdata_o, 16'h0000);
    endtask

    // linear modes on the x path
    task automatic test_x_modes;
        agen_partner_inst.issue('0, '0, wbr(4'h3, 16'h1000, 1'b0));
        agen_partner_inst.issue('0, '0, wbr(4'h5, 16'h0021, 1'b0));
        agen_partner_inst.issue('0, '0, wbr(4'h9, 16'h0400, 1'b1));
        x_chk(xr(AM_INDIRECT, 4'h3, 4'h0, 16'h0000, 1'b0, 1'b0), 16'h1000);
        cmp16({15'h0000, x_out_o.mem}, 16'h0001);
        x_chk(xr(AM_POST_MOD, 4'h3, 4'h0, 16'h0000, 1'b0, 1'b0), 16'h1000);
        x_chk(xr(AM_INDIRECT, 4'h3, 4'h0, 16'h0000, 1'b0, 1'b0), 16'h1002);
        x_chk(xr(AM_PRE_MOD, 4'h3, 4'h0, 16'h0000, 1'b1, 1'b0), 16'h1003);
        x_chk(xr(AM_PRE_MOD, 4'h3, 4'h0, 16'h0000, 1'b0, 1'b1), 16'h1001);
        x_chk(xr(AM_REG_OFFSET, 4'h3, 4'h5, 16'h0000, 1'b0, 1'b0), 16'h1022);
        x_chk(xr(AM_LIT_OFFSET, 4'h3, 4'h0, 16'h0100, 1'b0, 1'b0), 16'h1101);
        x_chk(xr(AM_FILE_DIRECT, 4'h0, 4'h0, 16'hffff, 1'b0, 1'b0), 16'h1fff);
        x_chk(xr(AM_INDIRECT, 4'h0, 4'h0, 16'h0000, 1'b0, 1'b0), 16'h0400);
        agen_partner_inst.issue(xr(AM_REG_DIRECT, 4'h5, 4'h0, 16'h0000, 1'b0, 1'b0), '0, '0);
        #1;
        cmp16({15'h0000, x_out_o.mem}, 16'h0000);
    endtask

    // whole data space for the move instruction, y beside x in one cycle
    task automatic test_move_and_y;
        x_req_t r;
        y_req_t y;
        r = xr(AM_FILE_DIRECT, 4'h0, 4'h0, 16'hffff, 1'b0, 1'b0);
        r.move_full = 1'b1;
        x_chk(r, 16'hffff);
        y = '0;
        y.valid = 1'b1;
        y.mode = AM_POST_MOD;
        y.ptr = 4'h5;
        y.step = 5'h02;
        agen_partner_inst.issue(xr(AM_POST_MOD, 4'h3, 4'h0, 16'h0000, 1'b0, 1'b0), y, '0);
        #1;
        cmp16(x_out_o.ea, 16'h1001);
        cmp16(y_out_o.ea, 16'h0020);
        y.mode = AM_INDIRECT;
        agen_partner_inst.issue(xr(AM_INDIRECT, 4'h3, 4'h0, 16'h0000, 1'b0, 1'b0), y, '0);
        #1;
        cmp16(x_out_o.ea, 16'h1003);
        cmp16(y_out_o.ea, 16'h0022);
    endtask

    // circular buffer of four bytes on the x path, then switched off
    task automatic test_circular;
        reg_wr(16'h0048, 16'h2000);
        reg_wr(16'h004a, 16'h2003);
        reg_wr(16'h0046, 16'h8ff4);
        agen_partner_inst.issue('0, '0, wbr(4'h4, 16'h2002, 1'b0));
        x_chk(xr(AM_POST_MOD, 4'h4, 4'h0, 16'h0000, 1'b0, 1'b0), 16'h2002);
        x_chk(xr(AM_POST_MOD, 4'h4, 4'h0, 16'h0000, 1'b0, 1'b0), 16'h2000);
        reg_wr(16'h0046, 16'h0ff4);
        x_chk(xr(AM_POST_MOD, 4'h4, 4'h0, 16'h0000, 1'b0, 1'b0), 16'h2002);
        x_chk(xr(AM_INDIRECT, 4'h4, 4'h0, 16'h0000, 1'b0, 1'b0), 16'h2004);
    endtask

    // pair write back, literal operands, flag pass-through, y circular buffer
    task automatic test_misc;
        x_req_t r;
        y_req_t y;
        wb_req_t w;
        w = wbr(4'h7, 16'haaaa, 1'b0);
        w.pair = 1'b1;
        w.data_hi = 16'h5555;
        agen_partner_inst.issue('0, '0, w);
        x_chk(xr(AM_INDIRECT, 4'h6, 4'h0, 16'h0000, 1'b0, 1'b0), 16'haaaa);
        x_chk(xr(AM_INDIRECT, 4'h7, 4'h0, 16'h0000, 1'b0, 1'b0), 16'h5555);
        r = xr(AM_LITERAL, 4'h0, 4'h0, 16'hffff, 1'b0, 1'b0);
        r.lit_wide = 1'b1;
        r.base_sel = 4'h3;
        r.write = 1'b1;
        r.prog = 1'b1;
        agen_partner_inst.issue(r, '0, '0);
        #1;
        cmp16(x_out_o.op2, 16'h03ff);
        cmp16(x_out_o.op1, 16'h1003);
        cmp16({13'h0000, x_out_o.mem, x_out_o.write, x_out_o.prog}, 16'h0003);
        r.lit_wide = 1'b0;
        agen_partner_inst.issue(r, '0, '0);
        #1;
        cmp16(x_out_o.op2, 16'h001f);
        reg_wr(16'h004c, 16'h3000);
        reg_wr(16'h004e, 16'h3007);
        reg_wr(16'h0046, 16'h4faf);
        agen_partner_inst.issue('0, '0, wbr(4'ha, 16'h3006, 1'b0));
        y = '0;
        y.valid = 1'b1;
        y.mode = AM_POST_MOD;
        y.ptr = 4'ha;
        y.step = 5'h04;
        agen_partner_inst.issue('0, y, '0);
        #1;
        cmp16(y_out_o.ea, 16'h3006);
        y.mode = AM_INDIRECT;
        agen_partner_inst.issue('0, y, '0);
        #1;
        cmp16(y_out_o.ea, 16'h3002);
        cmp16({15'h0000, y_out_o.valid}, 16'h0001);
    endtask

    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // main sequence
    initial
    begin
        repeat (8) @(posedge clk_sys_i);
        srst_i <= 1'b0;
        test_regs();
        test_x_modes();
        test_move_and_y();
        test_circular();
        test_misc();
        report_and_stop();
    end

    // watchdog well beyond the roughly 150 cycles the tests need
    initial
    begin
        repeat (5000) @(posedge clk_sys_i);
        n_mismatch++;
        report_and_stop();
    end
endmodule

// File: bench/agen_partner.sv
// decode stage stand-in that issues x, y and write back requests
// assumes the bench calls issue right after a rising edge of clk_sys_i
`timescale 1ns/1ns
module agen_partner (
    input wire logic clk_sys_i,
    output agen_pkg::x_req_t x_req_o,
    output agen_pkg::y_req_t y_req_o,
    output agen_pkg::wb_req_t wb_req_o
);
    import agen_pkg::*;

    // quiet ports until the first request
    initial
    begin
        x_req_o = '0;
        y_req_o = '0;
        wb_req_o = '0;
    end

    // one cycle of requests on all three ports, then withdraw with scrambled fields
    task automatic issue(input x_req_t xr, input y_req_t yr, input wb_req_t wr);
        x_req_t xi;
        y_req_t yi;
        wb_req_t wi;
        xi = ~xr;
        xi.valid = 1'b0;
        yi = ~yr;
        yi.valid = 1'b0;
        wi = ~wr;
        wi.valid = 1'b0;
        @(posedge clk_sys_i);
        x_req_o <= xr;
        y_req_o <= yr;
        wb_req_o <= wr;
        @(posedge clk_sys_i);
        x_req_o <= xi;
        y_req_o <= yi;
        wb_req_o <= wi;
    endtask
endmodule

// File: design/address_generator.sv
// x and y effective address generators with working registers and control map
// assumes decode supplies requests synchronous to clk_sys_i, one per path per cycle
`timescale 1ns/1ns

// Notes on behaviour
// - separate x and y generators run independently
// - y path serves only word reads
// - linear, circular and bit-reversed addressing supported
// - linear and circular usable for program space
// - bit reversal never applies to program space
// - file address field of 13 bits, near region
// - implied working register is register zero
// - result to file, implied register or pair
// - move instruction reaches whole data space
// - file direct takes address from instruction field
// - register direct gives register contents, no memory
// - indirect uses register value, register unchanged
// - post-modify: address first, then step register
// - pre-modify: step register, then use it
// - register offset: pointer plus offset register
// - literal offset: pointer plus instruction literal
// - first source always register direct
// - second source register, memory or 5-bit literal
// - result goes to register or memory
// - indirect modes plus 5 or 10-bit literals
// - x circular needs select not 15, bit 15
// - y circular needs bits 7:4 not 15, bit 14
module address_generator (
    input wire logic clk_sys_i,
    input wire logic srst_i,
    input wire logic [15:0] reg_addr_i,
    input wire logic [15:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire agen_pkg::x_req_t x_req_i,
    input wire agen_pkg::y_req_t y_req_i,
    input wire agen_pkg::wb_req_t wb_req_i,
    output agen_pkg::x_out_t x_out_o,
    output agen_pkg::y_out_t y_out_o,
    output logic [15:0] reg_rdata_o
);
    import agen_pkg::*;

    // step size: instruction value, else one byte or two word
    function automatic logic [DW-1:0] step_of(input logic ovr, input logic [STEP_W-1:0] stp,
                                              input logic byte_acc, input logic dec);
        logic [DW-1:0] mag;
        mag = ovr ? {{(DW-STEP_W){1'b0}}, stp} : (byte_acc ? STEP_BYTE : STEP_WORD);
        step_of = dec ? (ZERO16 - mag) : mag;
    endfunction

    // bit order reversal of a word
    function automatic logic [DW-1:0] brev(input logic [DW-1:0] v);
        brev = {<<{v}};
    endfunction

    // wrap an address into the circular buffer window
    function automatic logic [DW-1:0] wrap(input logic [DW-1:0] v, input logic [DW-1:0] s,
                                           input logic [DW-1:0] e);
        logic [DW-1:0] len;
        len = e - s + ONE16;
        if (v > e)
            wrap = v - len;
        else if (v < s)
            wrap = v + len;
        else
            wrap = v;
    endfunction

    // pointer select match, 15 disables
    function automatic logic sel_hit(input logic [RW-1:0] sel, input logic [RW-1:0] ptr);
        sel_hit = (sel != SEL_OFF) && (sel == ptr);
    endfunction

    logic [DW-1:0] implied_working_reg_r [NREG];
    logic [15:0] mode_ctl_r;
    logic [15:0] xs_r;
    logic [15:0] xe_r;
    logic [15:0] ys_r;
    logic [15:0] ye_r;
    logic [15:0] x_bit_reverse_control_r;
    logic [15:0] disi_r;
    logic [15:0] boot_segment_ram_control_r;
    logic [RW-1:0] x_pointer_select;
    logic [RW-1:0] y_pointer_select;
    logic [RW-1:0] reverse_pointer_select;
    logic x_circular_enable;
    logic y_circular_enable;
    logic reverse_enable;
    logic [DW-1:0] reverse_pivot;
    logic [DW-1:0] x_base;
    logic [DW-1:0] x_offs;
    logic [DW-1:0] x_op1;
    logic [DW-1:0] x_step;
    logic [DW-1:0] x_mod;
    logic x_circ;
    logic x_rev;
    logic x_upd;
    x_out_t x_out_nxt;
    logic [DW-1:0] y_base;
    logic [DW-1:0] y_mod;
    logic y_circ;
    logic y_upd;
    y_out_t y_out_nxt;
    logic [15:0] rdata_nxt;

    // control fields
    assign x_pointer_select = mode_ctl_r[X_SEL_LSB +: RW];
    assign y_pointer_select = mode_ctl_r[Y_SEL_LSB +: RW];
    assign reverse_pointer_select = mode_ctl_r[REV_SEL_LSB +: RW];
    assign x_circular_enable = mode_ctl_r[X_CIRC_EN_BIT];
    assign y_circular_enable = mode_ctl_r[Y_CIRC_EN_BIT];
    assign reverse_enable = x_bit_reverse_control_r[REV_EN_BIT];
    assign reverse_pivot = x_bit_reverse_control_r & PIVOT_MASK;

    // x path operand fetch and address arithmetic
    assign x_base = implied_working_reg_r[x_req_i.ptr];
    assign x_offs = implied_working_reg_r[x_req_i.offs];
    assign x_op1 = implied_working_reg_r[x_req_i.base_sel];
    assign x_step = step_of(x_req_i.step_ovr, x_req_i.step, x_req_i.byte_acc, x_req_i.dec);
    assign x_circ = x_circular_enable && sel_hit(x_pointer_select, x_req_i.ptr);
    assign x_rev = reverse_enable && sel_hit(reverse_pointer_select, x_req_i.ptr)
                   && (x_req_i.mode inside {AM_POST_MOD, AM_PRE_MOD}) && !x_req_i.dec
                   && x_req_i.write && !x_req_i.prog;

    // modified pointer: reversed-carry add, circular wrap or plain step
    always_comb
    begin
        if (x_rev)
            x_mod = brev(brev(x_base) + brev(reverse_pivot));
        else if (x_circ)
            x_mod = wrap(x_base + x_step, xs_r, xe_r);
        else
            x_mod = x_base + x_step;
    end

    // x mode decode
    always_comb
    begin
        x_out_nxt = '0;
        x_out_nxt.valid = x_req_i.valid;
        x_out_nxt.prog = x_req_i.prog;
        x_out_nxt.write = x_req_i.write;
        x_out_nxt.byte_acc = x_req_i.byte_acc;
        x_out_nxt.op1 = x_op1;
        x_out_nxt.mem = 1'b1;
        x_upd = 1'b0;
        unique case (x_req_i.mode)
            AM_FILE_DIRECT:
            begin
                if (x_req_i.move_full)
                    x_out_nxt.ea = x_req_i.lit;
                else
                    x_out_nxt.ea = {{(DW-NEAR_W){1'b0}}, x_req_i.lit[NEAR_W-1:0]};
            end
            AM_REG_DIRECT:
            begin
                x_out_nxt.mem = 1'b0;
                x_out_nxt.op2 = x_base;
            end
            AM_INDIRECT:
                x_out_nxt.ea = x_base;
            AM_POST_MOD:
            begin
                x_out_nxt.ea = x_base;
                x_upd = x_req_i.valid;
            end
            AM_PRE_MOD:
            begin
                x_out_nxt.ea = x_mod;
                x_upd = x_req_i.valid;
            end
            AM_REG_OFFSET:
                x_out_nxt.ea = x_circ ? wrap(x_base + x_offs, xs_r, xe_r) : x_base + x_offs;
            AM_LIT_OFFSET:
                x_out_nxt.ea = x_circ ? wrap(x_base + x_req_i.lit, xs_r, xe_r)
                                      : x_base + x_req_i.lit;
            AM_LITERAL:
            begin
                x_out_nxt.mem = 1'b0;
                if (x_req_i.lit_wide)
                    x_out_nxt.op2 = {{(DW-LIT_L_W){1'b0}}, x_req_i.lit[LIT_L_W-1:0]};
                else
                    x_out_nxt.op2 = {{(DW-LIT_S_W){1'b0}}, x_req_i.lit[LIT_S_W-1:0]};
            end
        endcase
    end

    // y path: word reads only, post-modify and offset forms
    assign y_base = implied_working_reg_r[y_req_i.ptr];
    assign y_circ = y_circular_enable && sel_hit(y_pointer_select, y_req_i.ptr);
    assign y_mod = y_circ ? wrap(y_base + step_of(1'b1, y_req_i.step, 1'b0, y_req_i.dec), ys_r, ye_r)
                          : y_base + step_of(1'b1, y_req_i.step, 1'b0, y_req_i.dec);

    // y mode decode
    always_comb
    begin
        y_out_nxt.valid = y_req_i.valid;
        y_upd = 1'b0;
        if (y_req_i.mode == AM_REG_OFFSET)
            y_out_nxt.ea = y_circ ? wrap(y_base + implied_working_reg_r[y_req_i.offs], ys_r, ye_r)
                                  : y_base + implied_working_reg_r[y_req_i.offs];
        else
            y_out_nxt.ea = y_base;
        if (y_req_i.mode == AM_POST_MOD)
            y_upd = y_req_i.valid;
        y_out_nxt.ea = y_out_nxt.ea & START_MASK;
    end

    // answer registers of both paths, each independent of the other
    always_ff @(posedge clk_sys_i)
    begin
        if (srst_i)
        begin
            x_out_o <= '0;
            y_out_o <= '0;
        end
        else
        begin
            x_out_o <= x_out_nxt;
            y_out_o <= y_out_nxt;
        end
    end

    // working registers: y then x pointer updates, result write back wins
    always_ff @(posedge clk_sys_i)
    begin
        if (srst_i)
        begin
            for (int i = 0; i < NREG; i++)
                implied_working_reg_r[i] <= WORKING_REG_RST;
        end
        else
        begin
            if (y_upd)
                implied_working_reg_r[y_req_i.ptr] <= y_mod & START_MASK;
            if (x_upd)
                implied_working_reg_r[x_req_i.ptr] <= x_mod;
            if (wb_req_i.valid)
            begin
                if (wb_req_i.implied)
                    implied_working_reg_r[WORKING_REG_ZERO] <= wb_req_i.data;
                else if (wb_req_i.pair)
                begin
                    implied_working_reg_r[{wb_req_i.idx[RW-1:1], 1'b0}] <= wb_req_i.data;
                    implied_working_reg_r[{wb_req_i.idx[RW-1:1], 1'b1}] <= wb_req_i.data_hi;
                end
                else
                    implied_working_reg_r[wb_req_i.idx] <= wb_req_i.data;
            end
        end
    end

    // control register writes
    always_ff @(posedge clk_sys_i)
    begin
        if (srst_i)
        begin
            mode_ctl_r <= ADDR_MODE_CONTROL_RST;
            xs_r <= CIRC_START_RST;
            xe_r <= CIRC_END_RST;
            ys_r <= CIRC_START_RST;
            ye_r <= CIRC_END_RST;
            x_bit_reverse_control_r <= X_BIT_REVERSE_CONTROL_RST;
            disi_r <= INTERRUPT_DISABLE_COUNTER_RST;
            boot_segment_ram_control_r <= BOOT_SEGMENT_RAM_CONTROL_RST;
        end
        else if (reg_wr_i)
        begin
            unique case (reg_addr_i)
                ADDR_MODE_CONTROL_OFS: mode_ctl_r <= reg_wdata_i & MODE_CONTROL_MASK;
                X_CIRCULAR_START_OFS: xs_r <= reg_wdata_i & START_MASK;
                X_CIRCULAR_END_OFS: xe_r <= reg_wdata_i | END_SET;
                Y_CIRCULAR_START_OFS: ys_r <= reg_wdata_i & START_MASK;
                Y_CIRCULAR_END_OFS: ye_r <= reg_wdata_i | END_SET;
                X_BIT_REVERSE_CONTROL_OFS: x_bit_reverse_control_r <= reg_wdata_i;
                INTERRUPT_DISABLE_COUNTER_OFS: disi_r <= reg_wdata_i & DISI_MASK;
                BOOT_SEGMENT_RAM_CONTROL_OFS: boot_segment_ram_control_r <= reg_wdata_i & BOOT_SEGMENT_RAM_CONTROL_MASK;
                default: ;
            endcase
        end
    end

    // read decode, unmapped addresses read zero
    always_comb
    begin
        unique case (reg_addr_i)
            ADDR_MODE_CONTROL_OFS: rdata_nxt = mode_ctl_r;
            X_CIRCULAR_START_OFS: rdata_nxt = xs_r;
            X_CIRCULAR_END_OFS: rdata_nxt = xe_r;
            Y_CIRCULAR_START_OFS: rdata_nxt = ys_r;
            Y_CIRCULAR_END_OFS: rdata_nxt = ye_r;
            X_BIT_REVERSE_CONTROL_OFS: rdata_nxt = x_bit_reverse_control_r;
            INTERRUPT_DISABLE_COUNTER_OFS: rdata_nxt = disi_r;
            BOOT_SEGMENT_RAM_CONTROL_OFS: rdata_nxt = boot_segment_ram_control_r;
            default: rdata_nxt = ZERO16;
        endcase
    end

    // read data stands one cycle after the strobe only
    always_ff @(posedge clk_sys_i)
    begin
        if (srst_i)
            reg_rdata_o <= ZERO16;
        else
            reg_rdata_o <= reg_rd_i ? rdata_nxt : ZERO16;
    end

    // checks of the address forms
    property p_indirect_ea;
        @(posedge clk_sys_i) disable iff (srst_i)
        (x_req_i.valid && x_req_i.mode == AM_INDIRECT)
        |=> (x_out_o.valid && x_out_o.mem && x_out_o.ea == $past(x_base));
    endproperty
    a_indirect_ea: assert property (p_indirect_ea) else $error("indirect address wrong");

    property p_indirect_keeps_ptr;
        @(posedge clk_sys_i) disable iff (srst_i)
        (x_req_i.valid && x_req_i.mode == AM_INDIRECT && !wb_req_i.valid && !y_upd)
        |=> (implied_working_reg_r[$past(x_req_i.ptr)] == $past(x_base));
    endproperty
    a_indirect_keeps_ptr: assert property (p_indirect_keeps_ptr) else $error("pointer changed");

    property p_file_near;
        @(posedge clk_sys_i) disable iff (srst_i)
        (x_req_i.mode == AM_FILE_DIRECT && !x_req_i.move_full)
        |=> (x_out_o.ea == {3'b000, $past(x_req_i.lit[12:0])});
    endproperty
    a_file_near: assert property (p_file_near) else $error("file address leaves near region");

    property p_move_full;
        @(posedge clk_sys_i) disable iff (srst_i)
        (x_req_i.mode == AM_FILE_DIRECT && x_req_i.move_full) |=> (x_out_o.ea == $past(x_req_i.lit));
    endproperty
    a_move_full: assert property (p_move_full) else $error("move address not full");

    property p_reg_direct;
        @(posedge clk_sys_i) disable iff (srst_i)
        (x_req_i.mode == AM_REG_DIRECT) |=> (!x_out_o.mem && x_out_o.op2 == $past(x_base));
    endproperty
    a_reg_direct: assert property (p_reg_direct) else $error("register direct wrong");

    property p_post_mod;
        @(posedge clk_sys_i) disable iff (srst_i)
        (x_req_i.valid && x_req_i.mode == AM_POST_MOD && !x_circ && !x_rev && !x_req_i.step_ovr
         && !x_req_i.dec && !x_req_i.byte_acc && !wb_req_i.valid && !y_upd)
        |=> (x_out_o.ea == $past(x_base) && implied_working_reg_r[$past(x_req_i.ptr)] == $past(x_base) + 16'h0002);
    endproperty
    a_post_mod: assert property (p_post_mod) else $error("post modify wrong");

    property p_reg_offset;
        @(posedge clk_sys_i) disable iff (srst_i)
        (x_req_i.mode == AM_REG_OFFSET && !x_circ) |=> (x_out_o.ea == $past(x_base + x_offs));
    endproperty
    a_reg_offset: assert property (p_reg_offset) else $error("register offset wrong");

    property p_y_word;
        @(posedge clk_sys_i) disable iff (srst_i)
        y_req_i.valid |=> (y_out_o.valid && !y_out_o.ea[0]);
    endproperty
    a_y_word: assert property (p_y_word) else $error("y address not word aligned");

    property p_lit_short;
        @(posedge clk_sys_i) disable iff (srst_i)
        (x_req_i.mode == AM_LITERAL && !x_req_i.lit_wide)
        |=> (!x_out_o.mem && x_out_o.op2 == {11'h000, $past(x_req_i.lit[4:0])});
    endproperty
    a_lit_short: assert property (p_lit_short) else $error("short literal wrong");

    property p_op1;
        @(posedge clk_sys_i) disable iff (srst_i)
        x_req_i.valid |=> (x_out_o.op1 == $past(x_op1));
    endproperty
    a_op1: assert property (p_op1) else $error("first operand wrong");
endmodule

// File: design/agen_pkg.sv
// constants, request and answer structs for the address generator
// assumes a 16-bit data space and a single core clock domain
package agen_pkg;
    // widths
    localparam int unsigned DW = 16;
    localparam int unsigned RW = 4;
    localparam int unsigned NEAR_W = 13;
    localparam int unsigned LIT_S_W = 5;
    localparam int unsigned LIT_L_W = 10;
    localparam int unsigned STEP_W = 5;
    localparam int unsigned NREG = 16;
    // register offsets
    localparam logic [15:0] ADDR_MODE_CONTROL_OFS = 16'h0046;
    localparam logic [15:0] X_CIRCULAR_START_OFS = 16'h0048;
    localparam logic [15:0] X_CIRCULAR_END_OFS = 16'h004a;
    localparam logic [15:0] Y_CIRCULAR_START_OFS = 16'h004c;
    localparam logic [15:0] Y_CIRCULAR_END_OFS = 16'h004e;
    localparam logic [15:0] X_BIT_REVERSE_CONTROL_OFS = 16'h0050;
    localparam logic [15:0] INTERRUPT_DISABLE_COUNTER_OFS = 16'h0052;
    localparam logic [15:0] BOOT_SEGMENT_RAM_CONTROL_OFS = 16'h0220;
    // reset values
    localparam logic [15:0] ADDR_MODE_CONTROL_RST = 16'h0000;
    localparam logic [15:0] CIRC_START_RST = 16'h0000;
    localparam logic [15:0] CIRC_END_RST = 16'h0001;
    localparam logic [15:0] X_BIT_REVERSE_CONTROL_RST = 16'h0000;
    localparam logic [15:0] INTERRUPT_DISABLE_COUNTER_RST = 16'h0000;
    localparam logic [15:0] BOOT_SEGMENT_RAM_CONTROL_RST = 16'h0000;
    localparam logic [15:0] WORKING_REG_RST = 16'h0000;
    // field positions and masks
    localparam int unsigned X_CIRC_EN_BIT = 15;
    localparam int unsigned Y_CIRC_EN_BIT = 14;
    localparam int unsigned REV_SEL_LSB = 8;
    localparam int unsigned Y_SEL_LSB = 4;
    localparam int unsigned X_SEL_LSB = 0;
    localparam int unsigned REV_EN_BIT = 15;
    localparam logic [RW-1:0] SEL_OFF = 4'hf;
    localparam logic [RW-1:0] WORKING_REG_ZERO = 4'h0;
    localparam logic [15:0] MODE_CONTROL_MASK = 16'hcfff;
    localparam logic [15:0] DISI_MASK = 16'h3fff;
    localparam logic [15:0] BOOT_SEGMENT_RAM_CONTROL_MASK = 16'h0007;
    localparam logic [15:0] PIVOT_MASK = 16'h7fff;
    localparam logic [15:0] START_MASK = 16'hfffe;
    localparam logic [15:0] END_SET = 16'h0001;
    localparam logic [15:0] ZERO16 = 16'h0000;
    localparam logic [15:0] ONE16 = 16'h0001;
    localparam logic [15:0] STEP_BYTE = 16'h0001;
    localparam logic [15:0] STEP_WORD = 16'h0002;

    typedef enum logic [2:0] {
        AM_FILE_DIRECT,
        AM_REG_DIRECT,
        AM_INDIRECT,
        AM_POST_MOD,
        AM_PRE_MOD,
        AM_REG_OFFSET,
        AM_LIT_OFFSET,
        AM_LITERAL
    } addr_mode_t;

    // x path request from the decode stage
    typedef struct packed {
        logic valid;
        addr_mode_t mode;
        logic [RW-1:0] ptr;
        logic [RW-1:0] offs;
        logic [RW-1:0] base_sel;
        logic [DW-1:0] lit;
        logic lit_wide;
        logic move_full;
        logic step_ovr;
        logic [STEP_W-1:0] step;
        logic dec;
        logic byte_acc;
        logic prog;
        logic write;
    } x_req_t;

    // y path request, word reads of the dual operand class only
    typedef struct packed {
        logic valid;
        addr_mode_t mode;
        logic [RW-1:0] ptr;
        logic [RW-1:0] offs;
        logic [STEP_W-1:0] step;
        logic dec;
    } y_req_t;

    // result write back to the working registers
    typedef struct packed {
        logic valid;
        logic implied;
        logic pair;
        logic [RW-1:0] idx;
        logic [DW-1:0] data;
        logic [DW-1:0] data_hi;
    } wb_req_t;

    typedef struct packed {
        logic valid;
        logic mem;
        logic [DW-1:0] ea;
        logic prog;
        logic write;
        logic byte_acc;
        logic [DW-1:0] op1;
        logic [DW-1:0] op2;
    } x_out_t;

    typedef struct packed {
        logic valid;
        logic [DW-1:0] ea;
    } y_out_t;
endpackage
